//--- core/ssm_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssm_consts.svh"

// Function
// - Either receive enable starts synchronous reception in master mode only
// - Master samples data on clock falling edge
// - Single enable receives one word, then stops
// - Continuous enable receives until software clears it
// - Both enables set behaves as continuous
// - Word done sets flag; interrupt only if enabled
// - Ninth bit and errors readable in control
// - Low eight received bits in data register
// - Clearing continuous enable clears receive errors
// - Polarity bit inverts the shift clock pin
// - Nine-bit select gives nine-bit received words
// - Clock source clear selects external slave clock
// - Slave transfers keep working in low power
// - Master only receives, slave only transmits; only master halts in sleep
// - Two writes then sleep: second stays buffered
// - After first word, reload and set empty flag
// - Empty flag wakes from sleep when enabled
// - Data write starts transmission when enabled
// - Idle clock level follows polarity bit
// - Empty flag cleared only by data write
// - Read-only shift register empty status bit
module ssm_core
(
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic [4:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output var  logic [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              shift_clock_pin_in,
    output logic                   shift_clock_pin_out,
    output logic                   shift_clock_pin_oe,
    input  wire logic              data_line_pin_in,
    output var  logic              data_line_pin_out,
    output logic                   data_line_pin_oe,
    input  wire logic              sleep_in,
    output var  logic              rx_irq,
    output var  logic              tx_irq,
    output var  logic              wake
);
    import ssm_pkg::*;

    // Bus handshake: every access waits exactly one cycle
    logic           ack_r;           // Second cycle of an access
    logic           req;             // Read or write pending
    logic           rd_acc;          // Read accepted this edge
    logic           wr_acc;          // Write accepted this edge
    logic           lane0;           // Low byte lane enabled
    ssm_byte_t      wb;              // Low byte of write data

    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    assign rd_acc          = avs_read & ack_r;
    assign wr_acc          = avs_write & ack_r;
    assign lane0           = avs_byteenable[0];
    assign wb              = avs_writedata[7:0];

    // Register write strobes, byte lane 0 only
    logic wr_rctl, wr_tctl, wr_baud, wr_divh, wr_divl, wr_tdata, wr_flags;
    assign wr_rctl  = wr_acc & lane0 & (avs_address == `SSM_OFF_RCTL);
    assign wr_tctl  = wr_acc & lane0 & (avs_address == `SSM_OFF_TCTL);
    assign wr_baud  = wr_acc & lane0 & (avs_address == `SSM_OFF_BAUD);
    assign wr_divh  = wr_acc & lane0 & (avs_address == `SSM_OFF_DIVH);
    assign wr_divl  = wr_acc & lane0 & (avs_address == `SSM_OFF_DIVL);
    assign wr_tdata = wr_acc & lane0 & (avs_address == `SSM_OFF_TDATA);
    assign wr_flags = wr_acc & lane0 & (avs_address == `SSM_OFF_FLAGS);

    // Reading received data acknowledges the receive flag
    logic rd_rdata;
    assign rd_rdata = rd_acc & (avs_address == `SSM_OFF_RDATA);

    // Control bits held for software
    logic      serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, address_detect_enable_r;
    logic      clock_source_select_r, tx9_r, transmit_enable_r, sync_r, brgh_r, ninth_transmit_bit_r;
    logic      pol_r, wide_r, rie_r, tie_r;
    ssm_byte_t divh_r, divl_r;

    // Status kept by the block
    logic      overrun_error_flag_r;           // Overrun, unread word overwritten by newer one
    logic      ninth_receive_bit_r;           // Ninth received bit
    logic      rxf_r;            // Receive flag
    ssm_byte_t rdata_r;          // Received low byte
    ssm_byte_t tbuf_r;           // Transmit buffer
    logic      tbuf_full_r;      // Transmit buffer holds a word
    logic      tsr_busy_r;       // Shift register holds a word

    // Pin synchronisers; first stages feed only second stages
    logic ck_m_r, ck_s_r, ck_d_r;
    logic dl_m_r, dl_s_r;

    always_ff @(posedge clk_sys)
    begin
        ck_m_r <= shift_clock_pin_in;
        ck_s_r <= ck_m_r;
        ck_d_r <= ck_s_r;
        dl_m_r <= data_line_pin_in;
        dl_s_r <= dl_m_r;
    end

    // Mode decode; receive enables override transmit
    ssm_mode_t mode;
    logic      rx_en;
    assign rx_en = single_receive_enable_r | continuous_receive_enable_r;
    assign mode  = !(serial_port_enable_r & sync_r) ? SSM_IDLE :
                   (clock_source_select_r & rx_en)   ? SSM_MRX  :
                   (!clock_source_select_r & transmit_enable_r & !rx_en) ? SSM_STX :
                   SSM_IDLE;

    // Word length for either direction
    logic [3:0] rx_bits, tx_bits;
    assign rx_bits = rx9_r ? `SSM_BITS_9 : `SSM_BITS_8;
    assign tx_bits = tx9_r ? `SSM_BITS_9 : `SSM_BITS_8;

    // Baud generator: half a clock period is divisor plus one cycles.
    // The generator is held off while sleep_in is high, though the system
    // clock keeps running, so a master receive freezes there while slave logic runs.
    logic [15:0] div;
    logic [15:0] bcnt_r;
    logic        master_run;
    logic        tick;
    assign div        = wide_r ? {divh_r, divl_r} : {8'h00, divl_r};
    assign master_run = (mode == SSM_MRX) & ~sleep_in;
    assign tick       = master_run & (bcnt_r == div);

    always_ff @(posedge clk_sys)
    begin
        if (srst || !master_run || tick)
            bcnt_r <= 16'h0000;
        else
            bcnt_r <= bcnt_r + 16'h0001;
    end

    // Internal master clock, low when idle before polarity
    logic       clk_int_r;
    logic       mfall;               // Falling edge of internal clock
    logic [3:0] rcnt_r;              // Bits taken in current word
    logic [8:0] rsh_r;               // Receive shift register
    logic [8:0] rsh_nxt;
    logic       rx_done;             // Last bit of a word sampled
    assign mfall   = tick & clk_int_r;
    assign rsh_nxt = {dl_s_r, rsh_r[8:1]};
    assign rx_done = mfall & (rcnt_r == rx_bits - 4'd1);

    always_ff @(posedge clk_sys)
    begin
        if (srst || mode != SSM_MRX)
            clk_int_r <= 1'b0;
        else if (tick)
            clk_int_r <= ~clk_int_r;
    end

    // Sample the data line on each falling edge, LSB first
    always_ff @(posedge clk_sys)
    begin
        if (srst || mode != SSM_MRX)
            rcnt_r <= 4'd0;
        else if (rx_done)
            rcnt_r <= 4'd0;
        else if (mfall)
            rcnt_r <= rcnt_r + 4'd1;
        if (srst)
            rsh_r <= 9'h000;
        else if (mfall)
            rsh_r <= rsh_nxt;
    end

    // Capture a finished word; 8-bit words sit in the top bits
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rdata_r <= 8'h00;
            ninth_receive_bit_r  <= 1'b0;
        end
        else if (rx_done)
        begin
            rdata_r <= rx9_r ? rsh_nxt[7:0] : rsh_nxt[8:1];
            ninth_receive_bit_r  <= rx9_r & rsh_nxt[8];
        end
    end

    // Flags: a setting event beats a clear in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rxf_r  <= 1'b0;
            overrun_error_flag_r <= 1'b0;
        end
        else
        begin
            if (rx_done)
                rxf_r <= 1'b1;
            else if (rd_rdata)
                rxf_r <= 1'b0;
            // An unread word is overwritten by the newer one, which marks an overrun
            if (rx_done && rxf_r && !rd_rdata)
                overrun_error_flag_r <= 1'b1;
            else if (!continuous_receive_enable_r)
                overrun_error_flag_r <= 1'b0;
        end
    end

    // Receive control writes; single enable self-clears after a word
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            {serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, address_detect_enable_r} <= 5'h00;
        else if (wr_rctl)
            {serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, address_detect_enable_r} <= wb[7:3];
        else if (rx_done && !continuous_receive_enable_r)
            single_receive_enable_r <= 1'b0;
    end

    // Transmit, baud and flag-enable control writes
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            {clock_source_select_r, tx9_r, transmit_enable_r, sync_r} <= 4'h0;
            {brgh_r, ninth_transmit_bit_r, pol_r, wide_r} <= 4'h0;
            {rie_r, tie_r, divh_r, divl_r}  <= 18'h00000;
        end
        else
        begin
            if (wr_tctl)
                {clock_source_select_r, tx9_r, transmit_enable_r, sync_r} <= wb[7:4];
            if (wr_tctl)
                {brgh_r, ninth_transmit_bit_r} <= {wb[`SSM_TC_BRGH], wb[`SSM_TC_NINTH_TRANSMIT_BIT]};
            if (wr_baud)
                {pol_r, wide_r} <= wb[4:3];
            if (wr_flags)
                {rie_r, tie_r} <= wb[5:4];
            if (wr_divh)
                divh_r <= wb;
            if (wr_divl)
                divl_r <= wb;
        end
    end

    // Slave clock edges after polarity, seen from synchronised samples
    logic srise, sfall;
    assign srise = (ck_s_r ^ pol_r) & ~(ck_d_r ^ pol_r);
    assign sfall = ~(ck_s_r ^ pol_r) & (ck_d_r ^ pol_r);

    // Transmit: buffer moves to the shift register when it is empty
    logic [8:0] tsr_r;
    logic [3:0] tcnt_r;
    logic       tload;
    logic       tx_last;
    assign tload   = (mode == SSM_STX) & tbuf_full_r & ~tsr_busy_r;
    assign tx_last = sfall & tsr_busy_r & (tcnt_r == tx_bits - 4'd1);

    // Buffer write always wins over the transfer out
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            tbuf_full_r <= 1'b0;
        else if (wr_tdata)
            tbuf_full_r <= 1'b1;
        else if (tload)
            tbuf_full_r <= 1'b0;
        if (srst)
            tbuf_r <= 8'h00;
        else if (wr_tdata)
            tbuf_r <= wb;
    end

    // Shift register; runs on the external clock, so also in sleep
    always_ff @(posedge clk_sys)
    begin
        if (srst || mode != SSM_STX)
        begin
            tsr_busy_r <= 1'b0;
            tcnt_r     <= 4'd0;
        end
        else if (tload)
        begin
            tsr_busy_r <= 1'b1;
            tcnt_r     <= 4'd0;
        end
        else if (tx_last)
            tsr_busy_r <= 1'b0;
        else if (sfall && tsr_busy_r)
            tcnt_r <= tcnt_r + 4'd1;
        if (srst)
            tsr_r <= 9'h000;
        else if (tload)
            tsr_r <= {ninth_transmit_bit_r, tbuf_r};
    end

    // Data pin: first bit at load, next bits on each active edge
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            data_line_pin_out <= 1'b0;
        else if (tload)
            data_line_pin_out <= tbuf_r[0];
        else if (srise && tsr_busy_r && tcnt_r != 4'd0)
            data_line_pin_out <= tsr_r[tcnt_r];
    end

    // Pins: master drives the clock, slave transmit drives data
    assign shift_clock_pin_out = clk_int_r ^ pol_r;
    assign shift_clock_pin_oe  = serial_port_enable_r & sync_r & clock_source_select_r;
    assign data_line_pin_oe    = (mode == SSM_STX);

    // Request and wake outputs, one cycle behind the flags
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            {rx_irq, tx_irq, wake} <= 3'b000;
        else
        begin
            rx_irq <= rxf_r & rie_r;
            tx_irq <= ~tbuf_full_r & tie_r;
            wake   <= sleep_in & ((rxf_r & rie_r) |
                                  (~tbuf_full_r & tie_r));
        end
    end

    // Read mux; reserved and unmapped bits read as zero
    ssm_byte_t rmux;
    always_comb
    begin
        unique case (avs_address)
            `SSM_OFF_RCTL:  rmux = {serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r,
                                    address_detect_enable_r, 1'b0, overrun_error_flag_r, ninth_receive_bit_r};
            `SSM_OFF_RDATA: rmux = rdata_r;
            `SSM_OFF_TCTL:  rmux = {clock_source_select_r, tx9_r, transmit_enable_r, sync_r,
                                    1'b0, brgh_r, ~tsr_busy_r, ninth_transmit_bit_r};
            `SSM_OFF_BAUD:  rmux = {3'b000, pol_r, wide_r, 3'b000};
            `SSM_OFF_DIVH:  rmux = divh_r;
            `SSM_OFF_DIVL:  rmux = divl_r;
            `SSM_OFF_TDATA: rmux = tbuf_r;
            `SSM_OFF_FLAGS: rmux = {2'b00, rie_r, tie_r, 2'b00,
                                    ~tbuf_full_r, rxf_r};
            default:        rmux = 8'h00;
        endcase
    end

    // Handshake state and registered read data
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ack_r        <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= req & ~ack_r;
            if (avs_read && !ack_r)
                avs_readdata <= {24'h00_0000, rmux};
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    property p_rx_sample;
        mfall && !rx_done |=> rcnt_r == $past(rcnt_r) + 4'd1;
    endproperty
    a_rx_sample: assert property (p_rx_sample)
        else $error("bit count not advanced on falling edge");

    property p_single_stop;
        rx_done && !continuous_receive_enable_r && !wr_rctl |=> !single_receive_enable_r && mode != SSM_MRX;
    endproperty
    a_single_stop: assert property (p_single_stop)
        else $error("single receive did not stop");

    property p_cont_keep;
        rx_done && continuous_receive_enable_r && !wr_rctl |=> continuous_receive_enable_r && mode == SSM_MRX;
    endproperty
    a_cont_keep: assert property (p_cont_keep)
        else $error("continuous receive stopped");

    property p_both_cont;
        rx_done && continuous_receive_enable_r && single_receive_enable_r && !wr_rctl |=> single_receive_enable_r;
    endproperty
    a_both_cont: assert property (p_both_cont)
        else $error("single enable cleared under continuous");

    property p_flag_irq;
        rx_done && rie_r && !wr_flags |=> rxf_r ##1 rx_irq;
    endproperty
    a_flag_irq: assert property (p_flag_irq)
        else $error("receive flag or request missing");

    property p_rx_data;
        rx_done && !rx9_r |=> rdata_r == $past(rsh_nxt[8:1]);
    endproperty
    a_rx_data: assert property (p_rx_data)
        else $error("received byte wrong");

    property p_err_clear;
        !continuous_receive_enable_r && !single_receive_enable_r |=> !overrun_error_flag_r;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("overrun not cleared");

    property p_idle_clock;
        (mode != SSM_MRX) [*2] |-> shift_clock_pin_out == pol_r;
    endproperty
    a_idle_clock: assert property (p_idle_clock)
        else $error("idle clock level wrong");

    property p_reload;
        tx_last && tbuf_full_r && !wr_tdata && mode == SSM_STX
            |=> ##1 tsr_busy_r && !tbuf_full_r;
    endproperty
    a_reload: assert property (p_reload)
        else $error("buffered word not reloaded");

    property p_flag_clear;
        $rose(tbuf_full_r) |-> $past(wr_tdata);
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("empty flag cleared without write");

    property p_data_edge;
        $changed(data_line_pin_out) |-> $past(tload) || $past(srise);
    endproperty
    a_data_edge: assert property (p_data_edge)
        else $error("data changed off the active edge");

    c_rx_word:   cover property (rx_done);
    c_overrun:   cover property (rx_done && rxf_r);
    c_tx_word:   cover property (tx_last);
    c_two_words: cover property (tx_last && tbuf_full_r && sleep_in);
endmodule
`default_nettype wire

//--- core/ssm_consts.svh
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH

// Register byte offsets on the Avalon-MM slave
`define SSM_OFF_RCTL   5'h00
`define SSM_OFF_RDATA  5'h04
`define SSM_OFF_TCTL   5'h08
`define SSM_OFF_BAUD   5'h0c
`define SSM_OFF_DIVH   5'h10
`define SSM_OFF_DIVL   5'h14
`define SSM_OFF_TDATA  5'h18
`define SSM_OFF_FLAGS  5'h1c

// Receive status/control field positions
`define SSM_RC_SERIAL_PORT_ENABLE    7
`define SSM_RC_RX9     6
`define SSM_RC_SINGLE_RECEIVE_ENABLE    5
`define SSM_RC_CONTINUOUS_RECEIVE_ENABLE    4
`define SSM_RC_ADDRESS_DETECT_ENABLE   3
`define SSM_RC_FRAMING_ERROR_FLAG    2
`define SSM_RC_OVERRUN_ERROR_FLAG    1
`define SSM_RC_NINTH_RECEIVE_BIT    0

// Transmit status/control field positions
`define SSM_TC_CLOCK_SOURCE_SELECT    7
`define SSM_TC_TX9     6
`define SSM_TC_TRANSMIT_ENABLE    5
`define SSM_TC_SYNC    4
`define SSM_TC_BRGH    2
`define SSM_TC_SHIFT_REGISTER_EMPTY    1
`define SSM_TC_NINTH_TRANSMIT_BIT    0

// Baud control and flag register field positions
`define SSM_BC_POL     4
`define SSM_BC_WIDE    3
`define SSM_FL_RXF     0
`define SSM_FL_TXF     1
`define SSM_FL_RIE     5
`define SSM_FL_TIE     4

// Word lengths in bits
`define SSM_BITS_8     4'd8
`define SSM_BITS_9     4'd9

`endif

//--- core/ssm_pkg.sv
package ssm_pkg;

    // One register byte
    typedef logic [7:0] ssm_byte_t;

    // Operating mode decoded from the control bits
    typedef enum logic [1:0] {
        SSM_IDLE,
        SSM_MRX,
        SSM_STX
    } ssm_mode_t;

endpackage

//--- test/ssm_peer.sv
`timescale 1ns/1ps
`default_nettype none

// Far-side synchronous peer: feeds a clock master, clocks a slave
module ssm_peer
(
    input  wire logic ck_line,  // Resolved shift clock line
    input  wire logic ck_oe,    // Device drives the clock
    input  wire logic dt_line,  // Resolved data line
    input  wire logic pol,      // Clock polarity in use
    output logic      peer_ck,  // Our clock drive, slave mode
    output var logic  peer_dt   // Our data drive, master receive
);
    logic [8:0] q[$];   // Words queued for the master to pull in
    logic [8:0] cur;    // Word on the wire
    int         idx;    // Next bit position
    int         nbits;  // Word length
    logic       live;   // A queued word is being sent
    logic       ck_int; // Our clock before polarity
    wire        ck_m;   // Device clock before polarity

    assign ck_m = ck_line ^ pol;
    // Pin level is the inner clock turned over by polarity
    assign peer_ck = ck_int ^ pol;

    initial
    begin
        cur = '0;
        idx = 0;
        nbits = 8;
        live = 1'b0;
        ck_int = 1'b1;
        peer_dt = 1'b0;
    end

    // Data changes on the rise so it has settled by the sampling fall
    always @(posedge ck_m)
    begin
        if (ck_oe)
        begin
            if (idx == 0 && q.size() != 0)
            begin
                cur = q.pop_front();
                live = 1'b1;
            end
            // No word queued: show a changing level, never a stale bit
            peer_dt = live ? cur[idx] : ~peer_dt;
            idx = idx + 1;
            if (idx == nbits)
            begin
                idx = 0;
                live = 1'b0;
            end
        end
    end

    // One slave frame, 200 ns bits; sample each fall, clock stands after
    task automatic frame(input int n, output logic [8:0] got);
        got = '0;
        #37;
        for (int i = 0; i < n; i++)
        begin
            ck_int = 1'b0;
            got[i] = dt_line;
            #100;
            ck_int = 1'b1;
            #100;
        end
    endtask
endmodule

`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssm_consts.svh"

module tb_top;
    import ssm_pkg::*;
    logic        clk_sys, srst, avs_read, avs_write, sleep_in;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic        avs_waitrequest, ck_out, ck_oe, dt_out, dt_oe;
    logic        rx_irq, tx_irq, wake, peer_ck, peer_dt, pol_r;
    wire         ck_line, dt_line;
    int          errors, total_checks, cyc;
    logic [8:0]  exp_q[$];  // Reference words, oldest first
    logic [7:0]  q, w0, w1;
    logic [8:0]  got;

    // Each line follows whoever enables its driver
    assign ck_line = ck_oe ? ck_out : peer_ck;
    assign dt_line = dt_oe ? dt_out : peer_dt;

    ssm_core i_ssm_core (.clk_sys(clk_sys), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .shift_clock_pin_in(ck_line),
        .shift_clock_pin_out(ck_out), .shift_clock_pin_oe(ck_oe),
        .data_line_pin_in(dt_line), .data_line_pin_out(dt_out),
        .data_line_pin_oe(dt_oe), .sleep_in(sleep_in), .rx_irq(rx_irq),
        .tx_irq(tx_irq), .wake(wake));

    ssm_peer i_ssm_peer (.ck_line(ck_line), .ck_oe(ck_oe),
        .dt_line(dt_line), .pol(pol_r), .peer_ck(peer_ck),
        .peer_dt(peer_dt));

    // 40 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Hang guard, far above the thousand or so cycles the run needs
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // One Avalon transfer; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [7:0] d, output logic [7:0] r);
        @(posedge clk_sys);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, d};
        // Waitrequest is looked at only on rising edges
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        r = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] r);
        bus(1'b0, a, 8'h00, r);
    endtask

    // Master receive of nw words; irq enabled only in continuous runs
    task automatic mrx(input logic nine, input logic pol,
                       input logic cont, input int nw);
        logic [8:0] w;
        logic [7:0] r, c;
        logic       bad;
        int         n;
        bad = 1'b0;
        pol_r = pol;
        i_ssm_peer.nbits = nine ? 9 : 8;
        wr(`SSM_OFF_BAUD, {3'h0, pol, 4'h0});
        // A polarity change can look like a clock rise to the peer
        i_ssm_peer.idx = 0;
        wr(`SSM_OFF_FLAGS, {2'h0, cont, 5'h0});
        for (int i = 0; i < nw; i++)
        begin
            w = 9'($urandom);
            i_ssm_peer.q.push_back(w);
            exp_q.push_back(w);
        end
        wr(`SSM_OFF_RCTL, {1'b1, nine, 1'b1, cont, 4'h0});
        for (int i = 0; i < nw; i++)
        begin
            n = 0;
            r = 8'h00;
            while (r[0] !== 1'b1 && n < 400)
            begin
                rd(`SSM_OFF_FLAGS, r);
                n++;
            end
            chk(r[0], 1'b1);
            w = exp_q.pop_front();
            chk(rx_irq, cont);
            chk(ck_oe, 1'b1);
            rd(`SSM_OFF_RCTL, c);
            rd(`SSM_OFF_RDATA, r);
            chk(r, w[7:0]);
            chk(c[0] & nine, w[8] & nine);
        end
        if (cont)
        begin
            // Unread words keep arriving, so an overrun must show
            repeat (400) @(posedge clk_sys);
            rd(`SSM_OFF_RCTL, c);
            chk(c[1], 1'b1);
            wr(`SSM_OFF_RCTL, 8'h80);
            rd(`SSM_OFF_RCTL, c);
            chk(c[1], 1'b0);
            repeat (10) @(posedge clk_sys);
        end
        else
            chk(c[5], 1'b0);
        // Clock must now rest at its idle level
        repeat (30)
        begin
            @(negedge clk_sys);
            if (ck_out !== pol)
                bad = 1'b1;
        end
        chk(bad, 1'b0);
    endtask

    initial
    begin
        srst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        sleep_in = 1'b0;
        pol_r = 1'b0;
        errors = 0;
        total_checks = 0;
        cyc = 0;
        void'($urandom(27969));
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        // Reset values, an unmapped place, a plain read-write register
        rd(`SSM_OFF_TCTL, q);
        chk(q, 8'h02);
        rd(`SSM_OFF_FLAGS, q);
        chk(q, 8'h02);
        rd(5'h02, q);
        chk(q, 8'h00);
        w0 = 8'($urandom);
        wr(`SSM_OFF_DIVL, w0);
        rd(`SSM_OFF_DIVL, q);
        chk(q, w0);
        // A write without its low byte lane must not land
        avs_byteenable <= 4'h0;
        wr(`SSM_OFF_DIVH, 8'h5a);
        avs_byteenable <= 4'hf;
        rd(`SSM_OFF_DIVH, q);
        chk(q, 8'h00);
        // Master receive setup, then single and continuous runs
        wr(`SSM_OFF_DIVL, 8'h03);
        wr(`SSM_OFF_TCTL, 8'h90);
        mrx(1'b0, 1'b0, 1'b0, 1);
        mrx(1'b1, 1'b1, 1'b1, 2);
        // Slave transmit in sleep: two words, peer supplies the clock
        wr(`SSM_OFF_RCTL, 8'h80);
        wr(`SSM_OFF_TCTL, 8'h30);
        wr(`SSM_OFF_FLAGS, 8'h10);
        @(posedge clk_sys);
        sleep_in <= 1'b1;
        w0 = 8'($urandom);
        w1 = 8'($urandom);
        wr(`SSM_OFF_TDATA, w0);
        wr(`SSM_OFF_TDATA, w1);
        rd(`SSM_OFF_FLAGS, q);
        chk(q[1], 1'b0);
        chk(wake, 1'b0);
        rd(`SSM_OFF_TCTL, q);
        chk(q[1], 1'b0);
        chk(dt_oe, 1'b1);
        chk(ck_oe, 1'b0);
        i_ssm_peer.frame(8, got);
        chk(got[7:0], w0);
        repeat (4) @(posedge clk_sys);
        rd(`SSM_OFF_FLAGS, q);
        chk(q[1], 1'b1);
        chk(wake, 1'b1);
        chk(tx_irq, 1'b1);
        i_ssm_peer.frame(8, got);
        chk(got[7:0], w1);
        repeat (4) @(posedge clk_sys);
        rd(`SSM_OFF_TCTL, q);
        chk(q[1], 1'b1);
        // Nine-bit word: ninth bit set up before the data write
        wr(`SSM_OFF_TCTL, {7'h38, w1[0]});
        wr(`SSM_OFF_TDATA, w0);
        i_ssm_peer.frame(9, got);
        chk(got, {w1[0], w0});
        repeat (4) @(posedge clk_sys);
        close_out();
    end
endmodule

`default_nettype wire
